// File: core/sram_port_params.svh
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH
// ==========================================================
// pin timing of the static memory, in ns
`define T_CLK_NS       20
`define T_CYCLE_NS     45
`define T_WRITE_NS     35
`define T_DATA_SU_NS   25
`define T_ACCESS_NS    45
`define T_TURN_NS      18
// cycle counts: least times round up, never below one
`define CEIL_CYC(t)    (((t) + `T_CLK_NS - 1) / `T_CLK_NS)
`define CYC_WRITE      `CEIL_CYC(`T_WRITE_NS)
`define CYC_CYCLE      `CEIL_CYC(`T_CYCLE_NS)
// read adds the two synchroniser flops behind the sampling edge
`define CYC_ACCESS     (`CEIL_CYC(`T_ACCESS_NS) + 2)
`define CYC_TURN       `CEIL_CYC(`T_TURN_NS)
// ==========================================================
// geometry
`define ADDR_BITS      17
`define DATA_BITS      16
`define LANE_LOW       0
`define LANE_HIGH      1
`endif

// File: core/sram_port_pkg.sv
`default_nettype none
package sram_port_pkg;
	// controller sequence states
	typedef enum logic [2:0] {
		idle_st,
		read_st,
		write_st,
		recover_st
	} seq_state_t;
	typedef logic [1:0] lane_sel_t;
endpackage
`default_nettype wire

// File: core/sram_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pin bundle between sequencer and pin driver
interface sram_pin_if;
	logic        chip_sel;
	logic        wr_strobe;
	logic        out_en;
	logic [1:0]  lanes;
	logic [16:0] addr;
	logic [15:0] wdata;
	logic        drive;
	modport seq (output chip_sel, output wr_strobe, output out_en,
		output lanes, output addr, output wdata, output drive);
	modport drv (input chip_sel, input wr_strobe, input out_en,
		input lanes, input addr, input wdata, input drive);
endinterface
`default_nettype wire

// File: core/sram_pin_drive.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_params.svh"
// ==========================================================
// pin registers: every memory pin leaves from a flip-flop
module sram_pin_drive (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	sram_pin_if.drv                     pins,
	output var logic                    chip_select_n,
	output var logic                    write_strobe_n,
	output var logic                    output_enable_n,
	output var logic                    upper_byte_enable_n,
	output var logic                    lower_byte_enable_n,
	output var logic [`ADDR_BITS-1:0]   mem_addr,
	output var logic [`DATA_BITS-1:0]   mem_data_out,
	output var logic [`DATA_BITS-1:0]   mem_data_oe
);
	// reset parks the memory deselected with the bus floating
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chip_select_n       <= 1'h1;
			write_strobe_n      <= 1'h1;
			output_enable_n     <= 1'h1;
			upper_byte_enable_n <= 1'h1;
			lower_byte_enable_n <= 1'h1;
			mem_addr            <= '0;
			mem_data_out        <= '0;
			mem_data_oe         <= '0;
		end else begin
			chip_select_n       <= ~pins.chip_sel;
			write_strobe_n      <= ~pins.wr_strobe;
			output_enable_n     <= ~pins.out_en;
			upper_byte_enable_n <= ~pins.lanes[`LANE_HIGH];
			lower_byte_enable_n <= ~pins.lanes[`LANE_LOW];
			mem_addr            <= pins.addr;
			mem_data_out        <= pins.wdata;
			mem_data_oe         <= {`DATA_BITS{pins.drive}};
		end
	end
endmodule
`default_nettype wire

// File: core/sram_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_params.svh"
// Functional notes
// - data valid at least 25 ns before the write-ending edge.
// - address stable 35 ns before write end, may change at start.
// - lanes, chip select and write strobe held 35 ns.
// - address valid no later than chip select and lane edges.
// - host never drives data while the memory drives.
module sram_host_ctrl #(
	parameter int ADDR_W = `ADDR_BITS,
	parameter int DATA_W = `DATA_BITS
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic                   req_write,
	input  wire logic [ADDR_W-1:0]      req_addr,
	input  wire logic [DATA_W-1:0]      req_wdata,
	input  wire sram_port_pkg::lane_sel_t req_lanes,
	output var logic                    rsp_valid,
	output var logic [DATA_W-1:0]       rsp_rdata,
	output var logic                    chip_select_n,
	output var logic                    write_strobe_n,
	output var logic                    output_enable_n,
	output var logic                    upper_byte_enable_n,
	output var logic                    lower_byte_enable_n,
	output var logic [ADDR_W-1:0]       mem_addr,
	input  wire logic [DATA_W-1:0]      mem_data_in,
	output var logic [DATA_W-1:0]       mem_data_out,
	output var logic [DATA_W-1:0]       mem_data_oe
);
	import sram_port_pkg::*;

	// phase lengths in clock cycles; each phase runs count+1 cycles
	// because the counter is loaded on entry and left at zero
	// write: strobes low for WR_CYC+1 cycles, which covers the
	// write pulse, the lane and select widths and the data setup
	// read: the memory may need its full access time after the
	// pin edge, and the sample then still crosses two flops
	// recovery: deselected gap, also the bus turnaround time
	// four bits hold the longest phase count with room to spare
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] WR_CYC  = CNT_W'(`CYC_WRITE);
	localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(`CYC_ACCESS);
	localparam logic [CNT_W-1:0] REC_CYC = CNT_W'(`CYC_TURN);

	// ==========================================================
	// state
	seq_state_t             state;
	seq_state_t             next_state;
	logic [CNT_W-1:0]       count;
	logic [CNT_W-1:0]       next_count;
	logic [ADDR_W-1:0]      addr;
	logic [DATA_W-1:0]      wdata;
	lane_sel_t              lanes;
	logic [DATA_W-1:0]      sync1;
	logic [DATA_W-1:0]      sync2;
	sram_pin_if             pins ();

	// ==========================================================
	// decoding
	// a request is taken only in idle, so a caller holds it until then
	wire start      = req_valid && req_ready;
	wire count_done = (count == '0);
	wire in_read    = (state == read_st);
	wire in_write   = (state == write_st);
	// zero lanes would be an empty access; treat it as both lanes
	wire [1:0] req_lanes_fix = (req_lanes == 2'h0) ? 2'h3 : req_lanes;
	// recovery gap is sized from bus turnaround only; each read or write phase alone exceeds the 45 ns cycle
	assign req_ready = (state == idle_st);

	// ==========================================================
	// pins: address and strobes change together at cycle start
	// every pin value below is registered once more in the pin
	// driver, so the memory sees a phase one cycle after the state
	// register enters it; all pins move on the same edge, so no
	// strobe can open a write before address and data are in place
	assign pins.addr      = addr;
	assign pins.chip_sel  = in_read || in_write;
	assign pins.wr_strobe = in_write;
	assign pins.lanes     = (in_read || in_write) ? lanes : 2'h0;
	// output enable stays high in writes so the memory floats
	assign pins.out_en    = in_read;
	assign pins.wdata     = wdata;
	assign pins.drive     = in_write;

	// ==========================================================
	// sequencer
	// next-state and counter logic; the counter is loaded on entry
	// to a phase and a phase is left on the cycle its count is zero
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
		idle_st: begin
			// wait for a request; its kind picks the phase
			if (start) begin
				next_state = req_write ? write_st : read_st;
				next_count = req_write ? WR_CYC : RD_CYC;
			end
		end
		read_st: begin
			// strobes stay low until the sample is safely in
			next_count = count - CNT_W'(1);
			if (count_done) begin
				next_state = recover_st;
				next_count = REC_CYC;
			end
		end
		write_st: begin
			// all strobes drop in one edge; the write ends there
			next_count = count - CNT_W'(1);
			if (count_done) begin
				next_state = recover_st;
				next_count = REC_CYC;
			end
		end
		recover_st: begin
			// pins already deselected; wait out the gap
			next_count = count - CNT_W'(1);
			if (count_done)
				next_state = idle_st;
		end
		default: begin
			// unused codes fall back to idle
			next_state = idle_st;
			next_count = '0;
		end
		endcase
	end

	// state and counter registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= idle_st;
			count <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// request capture
	// latched once, so the pins show it for the whole phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr     <= '0;
			wdata    <= '0;
			lanes    <= 2'h0;
		end else if (start) begin
			addr     <= req_addr;
			wdata    <= req_wdata;
			lanes    <= req_lanes_fix;
		end
	end

	// memory data arrives with no relation to the clock edge,
	// so it is resampled before any logic reads it
	// read data passes two flops; sampling late covers that lag
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= mem_data_in;
			sync2 <= sync1;
		end
	end

	// the answer pulses for one cycle at the end of every access;
	// a read takes the synchronised word at that same edge, so the
	// sample left the pins two edges earlier, late enough for a
	// full access time from the pin edge
	// answer: disabled lane reads as zero
	wire rd_take = in_read && count_done;
	wire [DATA_W-1:0] lane_mask = {{(DATA_W/2){lanes[`LANE_HIGH]}},
		{(DATA_W/2){lanes[`LANE_LOW]}}};
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rsp_valid <= 1'h0;
			rsp_rdata <= '0;
		end else begin
			rsp_valid <= rd_take || (in_write && count_done);
			if (rd_take)
				rsp_rdata <= sync2 & lane_mask;
		end
	end

	// ==========================================================
	// pin registers
	// registered pins: no decode glitch reaches the memory strobes
	sram_pin_drive u_drive (
		.core_clk            (core_clk),
		.rst                 (rst),
		.pins                (pins.drv),
		.chip_select_n       (chip_select_n),
		.write_strobe_n      (write_strobe_n),
		.output_enable_n     (output_enable_n),
		.upper_byte_enable_n (upper_byte_enable_n),
		.lower_byte_enable_n (lower_byte_enable_n),
		.mem_addr            (mem_addr),
		.mem_data_out        (mem_data_out),
		.mem_data_oe         (mem_data_oe)
	);
endmodule
`default_nettype wire

// File: testbench/sram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// behavioural static memory on the far side of the pins
module sram_dev_model #(
	parameter int ACC_NS = 22
) (
	input  wire logic        core_clk,
	input  wire logic        chip_select_n,
	input  wire logic        write_strobe_n,
	input  wire logic        output_enable_n,
	input  wire logic        upper_byte_enable_n,
	input  wire logic        lower_byte_enable_n,
	input  wire logic [16:0] mem_addr,
	input  wire logic [15:0] host_data,
	input  wire logic [15:0] host_oe,
	output wire logic [15:0] pin_data
);
	logic [15:0] mem [0:131071];
	logic [15:0] pat = 16'h5A3C;
	logic [15:0] wd;
	logic [16:0] wa;
	logic [1:0]  wl;
	wire logic [15:0] dev_q;
	// write only in the overlap, read only with strobe high and output on
	wire logic wr_act = !chip_select_n && !write_strobe_n && !(upper_byte_enable_n && lower_byte_enable_n);
	wire logic rd_act = !chip_select_n && write_strobe_n && !output_enable_n;
	wire logic [15:0] dev_en = rd_act ? {{8{!upper_byte_enable_n}}, {8{!lower_byte_enable_n}}} : 16'h0000;
	assign #(ACC_NS) dev_q = mem[mem_addr];
	// released lines wander so a stale value never passes
	assign pin_data = (host_oe & host_data) | (dev_en & dev_q) | (~(host_oe | dev_en) & pat);
	always @(posedge core_clk) begin
		pat <= {pat[14:0], ~pat[15]};
	end
	// sample before the edge so the end-of-write edge cannot race
	always @(posedge core_clk) begin
		if (wr_act) begin
			wa = mem_addr;
			wd = pin_data;
			wl = {!upper_byte_enable_n, !lower_byte_enable_n};
		end
	end
	// commit on whichever strobe ends the overlap
	always @(negedge wr_act) begin
		if (wl[0]) mem[wa][7:0] = wd[7:0];
		if (wl[1]) mem[wa][15:8] = wd[15:8];
	end
endmodule
`default_nettype wire

// File: testbench/sram_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// pin-side checks of the controller
module sram_host_monitor #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 16
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              chip_select_n,
	input  wire logic              write_strobe_n,
	input  wire logic              output_enable_n,
	input  wire logic              upper_byte_enable_n,
	input  wire logic              lower_byte_enable_n,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_data_out,
	input  wire logic [DATA_W-1:0] mem_data_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic lane_on = !(upper_byte_enable_n && lower_byte_enable_n);
	// two cycles is 40 ns, the least that covers 35 ns
	sequence s_wr_held;
		(!write_strobe_n && !chip_select_n && lane_on) [*2];
	endsequence
	property p_wr_width; $fell(write_strobe_n) |-> s_wr_held; endproperty
	property p_wr_end; $rose(write_strobe_n) |-> chip_select_n && !lane_on; endproperty
	property p_wr_addr; !write_strobe_n && $past(!write_strobe_n) |-> $stable(mem_addr); endproperty
	property p_wr_data; $rose(write_strobe_n) |-> $past(mem_data_oe) == '1 && $past(mem_data_out, 2) == $past(mem_data_out); endproperty
	property p_rd_quiet; !output_enable_n |-> mem_data_oe == '0; endproperty
	property p_oe_in_wr; mem_data_oe != '0 |-> !write_strobe_n && output_enable_n; endproperty
	property p_rd_addr; !output_enable_n && $past(!output_enable_n) |-> $stable(mem_addr); endproperty
	property p_gap; $rose(chip_select_n) |-> chip_select_n [*2]; endproperty
	a_wr_width: assert property (p_wr_width) else $error("write pulse short");
	a_wr_end: assert property (p_wr_end) else $error("strobes not ended together");
	a_wr_addr: assert property (p_wr_addr) else $error("address moved in write");
	a_wr_data: assert property (p_wr_data) else $error("data setup short");
	a_rd_quiet: assert property (p_rd_quiet) else $error("host drives in read");
	a_oe_in_wr: assert property (p_oe_in_wr) else $error("host drives outside write");
	a_rd_addr: assert property (p_rd_addr) else $error("address moved in read");
	a_gap: assert property (p_gap) else $error("cycle gap short");
endmodule
bind sram_host_ctrl sram_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sram_host_monitor (.core_clk, .rst, .chip_select_n, .write_strobe_n, .output_enable_n, .upper_byte_enable_n, .lower_byte_enable_n, .mem_addr, .mem_data_out, .mem_data_oe);
`default_nettype wire

// File: testbench/async_sram_byte_lane_port_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module async_sram_byte_lane_port_test;
	import sram_port_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [16:0] req_addr = 17'h00000;
	logic [15:0] req_wdata = 16'h0000;
	lane_sel_t   req_lanes = 2'h3;
	logic [15:0] rd;
	int          bad_count = 0;
	int          n_compared = 0;
	wire logic req_ready, rsp_valid, cs_n, we_n, oe_n, ub_n, lb_n;
	wire logic [15:0] rsp_rdata, d_out, d_oe, pin_data;
	wire logic [16:0] mem_addr;
	always #10 core_clk = ~core_clk;
	sram_host_ctrl u_sram_host_ctrl (.core_clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .req_lanes, .rsp_valid, .rsp_rdata, .chip_select_n(cs_n), .write_strobe_n(we_n), .output_enable_n(oe_n), .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n), .mem_addr, .mem_data_in(pin_data), .mem_data_out(d_out), .mem_data_oe(d_oe));
	// slowest legal memory: data valid only at the full access time
	sram_dev_model #(.ACC_NS(45)) u_sram_dev_model (.core_clk, .chip_select_n(cs_n), .write_strobe_n(we_n), .output_enable_n(oe_n), .upper_byte_enable_n(ub_n), .lower_byte_enable_n(lb_n), .mem_addr, .host_data(d_out), .host_oe(d_oe), .pin_data);
	task automatic end_sim;
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one request, held until taken, then wait for the answer
	task automatic xfer(input logic w, input logic [16:0] a, input logic [15:0] d, input lane_sel_t l);
		int n;
		@(negedge core_clk);
		{req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
		n = 0;
		while (req_ready !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
		if (n == 20) begin bad_count++; end_sim; end
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
		if (n == 20) begin bad_count++; end_sim; end
		rd = rsp_rdata;
	endtask
	// top address, and no lanes taken as both lanes
	task automatic t_full;
		xfer(1'b1, 17'h1FFFF, 16'hA55A, 2'h3);
		xfer(1'b1, 17'h00000, 16'h3CC3, 2'h0);
		xfer(1'b0, 17'h1FFFF, 16'h0000, 2'h3);
		`CHK(rd, 16'hA55A)
		xfer(1'b0, 17'h00000, 16'h0000, 2'h3);
		`CHK(rd, 16'h3CC3)
	endtask
	// single-lane writes over a full word, then single-lane reads
	task automatic t_lanes;
		xfer(1'b1, 17'h00100, 16'h1111, 2'h3);
		xfer(1'b1, 17'h00100, 16'h22EE, 2'h1);
		xfer(1'b0, 17'h00100, 16'h0000, 2'h3);
		`CHK(rd, 16'h11EE)
		xfer(1'b1, 17'h00100, 16'h4499, 2'h2);
		xfer(1'b0, 17'h00100, 16'h0000, 2'h3);
		`CHK(rd, 16'h44EE)
		xfer(1'b0, 17'h00100, 16'h0000, 2'h1);
		`CHK(rd, 16'h00EE)
		xfer(1'b0, 17'h00100, 16'h0000, 2'h2);
		`CHK(rd, 16'h4400)
	endtask
	initial begin
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		t_full;
		t_lanes;
		end_sim;
	end
	// about 12 transfers of under 12 cycles each
	initial begin
		#20000;
		bad_count++;
		end_sim;
	end
endmodule
`default_nettype wire
